// ---- hw/mpf_flow_ctrl.sv ----
// Purpose: Pause and backpressure flow control with AXI4-Lite registers
// Assumes: Receive bytes and transmit handshakes share sys_clk
// Notes:   Receive data is forwarded one cycle late, status one later
`timescale 1ns/1ps
module mpf_flow_ctrl
	import mpf_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        rx_valid,
	input  wire logic        rx_sof,
	input  wire logic        rx_eof,
	input  wire logic        rx_err,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_addr_match,
	output logic             host_valid,
	output logic             host_sof,
	output logic             host_eof,
	output logic [7:0]       host_data,
	output logic             stat_valid,
	output logic             stat_filter,
	output logic             stat_err,
	output logic             stat_pause,
	output logic             pause_frame_req,
	output logic [15:0]      pause_frame_time,
	input  wire logic        pause_frame_done,
	output logic             backpressure,
	output logic             tx_hold
);
	// Registers
	logic [15:0]   pause_time_value_q;
	logic          pass_control_frames_q;
	logic          pause_decode_enable_q;
	logic [5:0]    cfg_q;
	logic          send_pend_q;
	mpf_fc_state_t fc_q;
	mpf_fc_state_t fc_d;
	logic          aw_have_q;
	logic          w_have_q;
	logic [11:0]   aw_addr_q;
	logic [31:0]   w_data_q;
	logic [3:0]    w_strb_q;
	logic          err_hold_q;
	logic          match_hold_q;
	// Decode and status wires
	logic          full_dup_w;
	logic          tx_en_w;
	logic          wr_fire_w;
	logic          wr_ctrl_w;
	logic          wr_cfg_w;
	logic          send_req_w;
	logic          rd_fire_w;
	logic [31:0]   ctrl_rd_w;
	logic [31:0]   ctrl_wr_w;
	logic [31:0]   rd_mux_w;
	logic          rd_hit_w;
	logic          dec_done_w;
	logic          dec_pause_w;
	logic [15:0]   dec_quanta_w;
	logic          pause_load_w;
	logic [15:0]   hold_cnt_w;
	logic          busy_w;
	logic          bp_want_w;

	// Lane merge for byte-enabled writes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		merge = r;
	endfunction : merge

	// Configuration views
	assign full_dup_w = cfg_q[BIT_FULL_DUP];
	assign tx_en_w    = cfg_q[BIT_TX_EN];
	assign busy_w     = fc_q != FC_IDLE;
	assign ctrl_rd_w  = {pause_time_value_q, 13'h0000, pass_control_frames_q,
		pause_decode_enable_q, busy_w};
	assign ctrl_wr_w  = merge(ctrl_rd_w, w_data_q, w_strb_q);

	// Write decode
	assign wr_fire_w = aw_have_q && w_have_q && !s_axi_bvalid;
	assign wr_ctrl_w = wr_fire_w && aw_addr_q == ADDR_PAUSE_CTRL;
	assign wr_cfg_w  = wr_fire_w && aw_addr_q == ADDR_FC_CFG;
	assign send_req_w = wr_cfg_w && w_strb_q[0] && w_data_q[BIT_SEND_PAUSE];

	// Read decode
	assign rd_fire_w = s_axi_arvalid && s_axi_arready;
	assign rd_hit_w  = s_axi_araddr == ADDR_PAUSE_CTRL
		|| s_axi_araddr == ADDR_FC_CFG || s_axi_araddr == ADDR_FC_STAT;
	assign rd_mux_w  = (s_axi_araddr == ADDR_PAUSE_CTRL) ? ctrl_rd_w :
		(s_axi_araddr == ADDR_FC_CFG) ? {26'h0000000, cfg_q} :
		(s_axi_araddr == ADDR_FC_STAT) ? {hold_cnt_w, 13'h0000,
			backpressure, tx_hold, busy_w} : 32'h0000_0000;

	// Write address and data taken in either order
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			aw_addr_q     <= 12'h000;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_q <= 1'b1;
				aw_addr_q <= {s_axi_awaddr[11:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire_w)
			begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_ctrl_w || wr_cfg_w
					|| aw_addr_q == ADDR_FC_STAT) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel, one read at a time
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rd_fire_w)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux_w;
				s_axi_rresp  <= rd_hit_w ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Software registers; the busy position is read-only
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			pause_time_value_q    <= PAUSE_CTRL_RST[31:16];
			pass_control_frames_q <= PAUSE_CTRL_RST[BIT_PASS_CF];
			pause_decode_enable_q <= PAUSE_CTRL_RST[BIT_DEC_EN];
			cfg_q                 <= FC_CFG_RST;
		end
		else
		begin
			if (wr_ctrl_w)
			begin
				{pause_time_value_q, pass_control_frames_q,
					pause_decode_enable_q} <= {ctrl_wr_w[31:PT_LSB],
					ctrl_wr_w[BIT_PASS_CF], ctrl_wr_w[BIT_DEC_EN]};
			end
			if (wr_cfg_w && w_strb_q[0])
				cfg_q <= w_data_q[5:0] & ~(6'h01 << BIT_SEND_PAUSE);
		end
	end

	// Pause frame request pending; a new request wins over the take
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			send_pend_q <= 1'b0;
		else if (send_req_w)
			send_pend_q <= 1'b1;
		else if (fc_q == FC_IDLE || !tx_en_w || !full_dup_w)
			send_pend_q <= 1'b0;
	end

	// Backpressure wanted only in half duplex with transmitter on
	assign bp_want_w = !full_dup_w && pause_decode_enable_q
		&& cfg_q[BIT_BP_REQ] && tx_en_w;

	// Transmit flow state machine
	always_comb
	begin
		fc_d = fc_q;
		case (fc_q)
			FC_IDLE:
				if (send_pend_q && full_dup_w && tx_en_w)
					fc_d = FC_SEND;
				else if (bp_want_w)
					fc_d = FC_BACK;
			FC_SEND:
				if (pause_frame_done || !tx_en_w)
					fc_d = FC_IDLE;
			FC_BACK:
				if (!bp_want_w)
					fc_d = FC_IDLE;
			default:
				fc_d = FC_IDLE;
		endcase
	end

	// State and transmit side outputs
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			fc_q             <= FC_IDLE;
			pause_frame_req  <= 1'b0;
			pause_frame_time <= 16'h0000;
			backpressure     <= 1'b0;
		end
		else
		begin
			fc_q             <= fc_d;
			pause_frame_req  <= fc_d == FC_SEND;
			pause_frame_time <= pause_time_value_q;
			backpressure     <= fc_d == FC_BACK;
		end
	end

	// Pause frame recogniser
	mpf_pause_rx u_rx (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.dec_en   (pause_decode_enable_q),
		.rx_valid (rx_valid),
		.rx_sof   (rx_sof),
		.rx_eof   (rx_eof),
		.rx_err   (rx_err),
		.rx_data  (rx_data),
		.done     (dec_done_w),
		.is_pause (dec_pause_w),
		.quanta   (dec_quanta_w)
	);

	// Act on pause only in full duplex with decode enabled
	assign pause_load_w = dec_done_w && dec_pause_w && full_dup_w
		&& pause_decode_enable_q;

	// Hold-off counter
	mpf_holdoff u_hold (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.speed_100 (cfg_q[BIT_SPEED_100]),
		.load      (pause_load_w),
		.quanta    (dec_quanta_w),
		.count     (hold_cnt_w)
	);

	// Every frame is forwarded to the host
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			host_valid   <= 1'b0;
			host_sof     <= 1'b0;
			host_eof     <= 1'b0;
			host_data    <= 8'h00;
			err_hold_q   <= 1'b0;
			match_hold_q <= 1'b0;
		end
		else
		begin
			host_valid   <= rx_valid;
			host_sof     <= rx_valid && rx_sof;
			host_eof     <= rx_valid && rx_eof;
			host_data    <= rx_data;
			err_hold_q   <= rx_err;
			match_hold_q <= rx_addr_match;
		end
	end

	// Receive status and hold-off output
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			stat_valid  <= 1'b0;
			stat_filter <= 1'b0;
			stat_err    <= 1'b0;
			stat_pause  <= 1'b0;
			tx_hold     <= 1'b0;
		end
		else
		begin
			stat_valid <= dec_done_w;
			stat_err   <= err_hold_q;
			stat_pause <= dec_pause_w;
			if (cfg_q[BIT_PROMISC])
				stat_filter <= 1'b1;
			else if (dec_pause_w)
				stat_filter <= pass_control_frames_q;
			else
				stat_filter <= match_hold_q;
			tx_hold <= pause_load_w ? (dec_quanta_w != 16'h0000)
				: (hold_cnt_w != 16'h0000);
		end
	end
endmodule : mpf_flow_ctrl

// ---- hw/mpf_holdoff.sv ----
// Purpose: Transmit hold-off counter in pause quanta
// Assumes: load is a one-cycle pulse with the decoded pause time
// Notes:   Slot divider restarts on load so each quantum is whole
`timescale 1ns/1ps
module mpf_holdoff
	import mpf_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        speed_100,
	input  wire logic        load,
	input  wire logic [15:0] quanta,
	output logic [15:0]      count
);
	logic [10:0] div_q;
	logic        tick_w;

	// One slot time per tick
	assign tick_w = div_q == ((speed_100 ? SLOT_CYC_100 : SLOT_CYC_10) - 11'h001);

	// Reload on a new pause, count down per slot
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			div_q <= 11'h000;
			count <= 16'h0000;
		end
		else if (load)
		begin
			div_q <= 11'h000;
			count <= quanta;
		end
		else
		begin
			div_q <= tick_w ? 11'h000 : div_q + 11'h001;
			if (tick_w && count != 16'h0000)
				count <= count - 16'h0001;
		end
	end
endmodule : mpf_holdoff

// ---- hw/mpf_pause_rx.sv ----
// Purpose: Recognise a valid pause frame in the receive byte stream
// Assumes: Bytes arrive on the system clock with start and end marks
// Notes:   Result is a one-cycle pulse the cycle after the last byte
`timescale 1ns/1ps
module mpf_pause_rx
	import mpf_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        dec_en,
	input  wire logic        rx_valid,
	input  wire logic        rx_sof,
	input  wire logic        rx_eof,
	input  wire logic        rx_err,
	input  wire logic [7:0]  rx_data,
	output logic             done,
	output logic             is_pause,
	output logic [15:0]      quanta
);
	logic [4:0]  pos_q;
	logic        match_q;
	logic [15:0] time_q;
	logic [4:0]  pos_w;
	logic        byte_ok_w;
	logic        match_w;

	// Expected byte of the control address, type and opcode
	function automatic logic [7:0] exp_byte(input logic [4:0] p);
		case (p)
			5'h00:   exp_byte = 8'h01;
			5'h01:   exp_byte = 8'h80;
			5'h02:   exp_byte = 8'hC2;
			5'h05:   exp_byte = 8'h01;
			5'h0C:   exp_byte = 8'h88;
			5'h0D:   exp_byte = 8'h08;
			5'h0F:   exp_byte = 8'h01;
			default: exp_byte = 8'h00;
		endcase
	endfunction : exp_byte

	// Byte position and per-byte compare
	assign pos_w     = rx_sof ? 5'h00 : pos_q;
	assign byte_ok_w = (pos_w > POS_LAST_CHK) || (pos_w > 5'h05 && pos_w < 5'h0C)
		|| (rx_data == exp_byte(pos_w));
	assign match_w   = (rx_sof ? 1'b1 : match_q) && byte_ok_w;

	// Walk the frame
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			pos_q    <= 5'h00;
			match_q  <= 1'b0;
			time_q   <= 16'h0000;
			done     <= 1'b0;
			is_pause <= 1'b0;
			quanta   <= 16'h0000;
		end
		else
		begin
			done <= rx_valid && rx_eof;
			if (rx_valid)
			begin
				pos_q   <= (pos_w == 5'h1F) ? pos_w : pos_w + 5'h01;
				match_q <= match_w;
				if (pos_w == POS_TIME_HI)
					time_q[15:8] <= rx_data;
				if (pos_w == POS_TIME_LO)
					time_q[7:0] <= rx_data;
				if (rx_eof)
				begin
					is_pause <= dec_en && match_w && !rx_err && pos_w > POS_TIME_LO;
					quanta   <= time_q;
				end
			end
		end
	end
endmodule : mpf_pause_rx

// ---- hw/mpf_pkg.sv ----
// Purpose: Shared constants for the pause flow control block
// Assumes: 25 MHz system clock, AXI4-Lite with 32-bit data
// Notes:   Register indices are word numbers; byte address is index * 4
package mpf_pkg;
	localparam int          CLK_MHZ        = 25;
	// Register indices and byte addresses
	localparam logic [7:0]  IDX_PAUSE_CTRL = 8'h08;
	localparam logic [7:0]  IDX_FC_CFG     = 8'h10;
	localparam logic [7:0]  IDX_FC_STAT    = 8'h11;
	localparam logic [11:0] ADDR_PAUSE_CTRL = {2'h0, IDX_PAUSE_CTRL, 2'h0};
	localparam logic [11:0] ADDR_FC_CFG     = {2'h0, IDX_FC_CFG, 2'h0};
	localparam logic [11:0] ADDR_FC_STAT    = {2'h0, IDX_FC_STAT, 2'h0};
	// Pause control fields
	localparam int          PT_LSB         = 16;
	localparam int          BIT_PASS_CF    = 2;
	localparam int          BIT_DEC_EN     = 1;
	localparam int          BIT_TX_BUSY    = 0;
	localparam logic [31:0] PAUSE_CTRL_RST = 32'h0000_0000;
	// Configuration fields
	localparam int          BIT_FULL_DUP   = 0;
	localparam int          BIT_TX_EN      = 1;
	localparam int          BIT_PROMISC    = 2;
	localparam int          BIT_SEND_PAUSE = 3;
	localparam int          BIT_BP_REQ     = 4;
	localparam int          BIT_SPEED_100  = 5;
	localparam logic [5:0]  FC_CFG_RST     = 6'h00;
	// Bus responses
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	// Slot time, one pause quantum, in ns per link speed
	localparam int          SLOT_NS_100    = 5120;
	localparam int          SLOT_NS_10     = 51200;
	localparam logic [10:0] SLOT_CYC_100   = 11'(SLOT_NS_100 * CLK_MHZ / 1000);
	localparam logic [10:0] SLOT_CYC_10    = 11'(SLOT_NS_10 * CLK_MHZ / 1000);
	// Pause frame layout
	localparam logic [4:0]  POS_TIME_HI    = 5'h10;
	localparam logic [4:0]  POS_TIME_LO    = 5'h11;
	localparam logic [4:0]  POS_LAST_CHK   = 5'h0F;
	// Transmit flow states
	typedef enum logic [2:0] {
		FC_IDLE = 3'b001,
		FC_SEND = 3'b010,
		FC_BACK = 3'b100
	} mpf_fc_state_t;
endpackage : mpf_pkg

// ---- tb/mpf_flow_chk.sv ----
// Purpose: Port checks for the pause flow control block
// Assumes: sys_clk rising edge, rst active high
// Notes:   Bound to every mpf_flow_ctrl instance
`timescale 1ns/1ps
module mpf_flow_chk
	import mpf_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        rx_valid,
	input wire logic        rx_sof,
	input wire logic        rx_eof,
	input wire logic [7:0]  rx_data,
	input wire logic        host_valid,
	input wire logic        host_sof,
	input wire logic        host_eof,
	input wire logic [7:0]  host_data,
	input wire logic        stat_valid,
	input wire logic        stat_pause,
	input wire logic        pause_frame_req,
	input wire logic        pause_frame_done,
	input wire logic        backpressure,
	input wire logic        tx_hold
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// Receive forwarding and status timing
	host_mirror_a: assert property (rx_valid |=> host_valid && host_data == $past(rx_data))
		else $error("receive byte not forwarded");
	edge_mirror_a: assert property (rx_valid |=> host_sof == $past(rx_sof) && host_eof == $past(rx_eof))
		else $error("frame marks not forwarded");
	stat_after_a: assert property (host_eof |=> stat_valid)
		else $error("status missing after frame end");
	hold_cause_a: assert property ($rose(tx_hold) |-> stat_valid && stat_pause)
		else $error("hold-off without a pause frame");
	// Pause request handshake
	req_hold_a: assert property (pause_frame_req && !pause_frame_done |=> pause_frame_req)
		else $error("pause request dropped early");
	req_end_a: assert property (pause_frame_req && pause_frame_done |=> !pause_frame_req [*2])
		else $error("pause request stayed after done");
	fc_excl_a: assert property (not (backpressure && pause_frame_req))
		else $error("pause request during backpressure");
	// Bus answers
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	// Main scenarios
	pause_seen_c: cover property (stat_valid && stat_pause);
	bp_seen_c: cover property (backpressure);
	req_done_c: cover property (pause_frame_req && pause_frame_done);
endmodule : mpf_flow_chk

bind mpf_flow_ctrl mpf_flow_chk u_chk (.*);

// ---- tb/mpf_mac_tx_model.sv ----
// Purpose: Transmit side that sends the requested pause frame
// Assumes: Request is a level held until done
// Notes:   Done pulses once, delay plus one cycles after the request
`timescale 1ns/1ps
module mpf_mac_tx_model
(
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic       pause_frame_req,
	input wire logic [7:0] delay,
	output logic           pause_frame_done
);
	logic       busy_w;
	logic [7:0] wait_q;
	assign busy_w = pause_frame_req && !pause_frame_done;
	// Count the frame out, then report its end once
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wait_q           <= 8'h00;
			pause_frame_done <= 1'b0;
		end
		else
		begin
			pause_frame_done <= busy_w && wait_q == delay;
			wait_q           <= (busy_w && wait_q != delay) ? wait_q + 8'h01 : 8'h00;
		end
	end
endmodule : mpf_mac_tx_model

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the pause flow control block
// Assumes: Bench is the bus master and the receive source
// Notes:   Results are compared against queued notes
`timescale 1ns/1ps
module tb_top;
	import mpf_pkg::*;
	logic        sys_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, rx_valid, rx_sof, rx_eof;
	logic        rx_err, rx_addr_match, pause_frame_done, s_axi_awready;
	logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        host_valid, host_sof, host_eof, stat_valid, stat_filter;
	logic        stat_err, stat_pause, pause_frame_req, backpressure, tx_hold;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, lfsr_q, rd;
	logic [3:0]  s_axi_wstrb;
	logic [7:0]  rx_data, host_data, tx_dly;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [15:0] pause_frame_time, t;
	logic [67:0] bq[$], sq[$];
	logic [7:0]  hdr [16] = '{8'h01, 8'h80, 8'hC2, 8'h00, 8'h00, 8'h01,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h88, 8'h08, 8'h00, 8'h01};
	int          num_errors = 0;
	int          check_count = 0;
	mpf_flow_ctrl u_dut (.*);
	mpf_mac_tx_model u_mac (.sys_clk(sys_clk), .rst(rst),
		.pause_frame_req(pause_frame_req), .delay(tx_dly),
		.pause_frame_done(pause_frame_done));
	function automatic logic [31:0] nxt(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : nxt
	task automatic chk(input string nm, input logic [67:0] e, input logic [33:0] g);
		check_count++;
		if ((g & e[67:34]) !== e[33:0])
		begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", nm, e[33:0], g & e[67:34]);
		end
	endtask : chk
	task automatic summarize();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw, w;
		aw = 0;
		w = 0;
		bq.push_back({2'h3, 32'h0, r, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w))
		begin
			@(posedge sys_clk);
			aw = aw | (s_axi_awready === 1'b1);
			w = w | (s_axi_wready === 1'b1);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
	endtask : wr
	task automatic rdr(input logic [11:0] a, input logic [31:0] m, v, input logic [1:0] r);
		bq.push_back({2'h3, m, r, v & m});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
	endtask : rdr
	// Wait for busy to clear before touching pause control
	task automatic wfc(input logic [31:0] d);
		do rdr(ADDR_PAUSE_CTRL, 32'h0, 32'h0, RESP_OKAY); while (rd[0] !== 1'b0);
		wr(ADDR_PAUSE_CTRL, d & 32'hFFFF_FFFE, RESP_OKAY);
	endtask : wfc
	task automatic rxf(input logic pf, e, am, input logic [15:0] pt, input logic [2:0] x, m);
		logic [7:0] b;
		sq.push_back({31'h0, m, 31'h0, x & m});
		for (int i = 0; i < 22; i++)
		begin
			lfsr_q = nxt(lfsr_q);
			b = (i < 16) ? hdr[i] : (i == 16) ? pt[15:8] : (i == 17) ? pt[7:0] : lfsr_q[7:0];
			if (i > 5 && i < 12) b = lfsr_q[7:0];
			if (i == 0 && !pf) b = 8'hFF;
			rx_valid <= 1'b1;
			rx_sof <= (i == 0);
			rx_eof <= (i == 21);
			rx_err <= (i == 21) && e;
			rx_addr_match <= am;
			rx_data <= b;
			@(posedge sys_clk);
		end
		rx_valid <= 1'b0;
		rx_eof <= 1'b0;
		@(posedge sys_clk);
	endtask : rxf
	// Count cycles of transmit hold-off
	task automatic hm(input int lo, hi);
		int n;
		n = 0;
		while (tx_hold !== 1'b1 && n < 40)
		begin
			@(posedge sys_clk);
			n++;
		end
		n = 0;
		while (tx_hold === 1'b1)
		begin
			@(posedge sys_clk);
			n++;
		end
		chk($sformatf("hold %0d", n), {34'h1, 34'h1}, {33'h0, n >= lo && n <= hi});
	endtask : hm
	// Compare results against the oldest note
	always @(posedge sys_clk)
	begin
		if (stat_valid === 1'b1)
			chk("stat", sq.size() ? sq.pop_front() : '1, {31'h0, stat_filter, stat_pause, stat_err});
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
			chk("read", bq.size() ? bq.pop_front() : '1, {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
			chk("bresp", bq.size() ? bq.pop_front() : '1, {s_axi_bresp, 32'h0});
	end
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		summarize();
	end
	initial
	begin
		logic [2:0] c;
		logic       am;
		rst = 1'b1;
		lfsr_q = 32'h0CA7;
		tx_dly = 8'h00;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{rx_valid, rx_sof, rx_eof, rx_err, rx_addr_match, rx_data} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		// Reset values, refusals and a pause control write with the busy bit masked off
		rdr(ADDR_PAUSE_CTRL, '1, PAUSE_CTRL_RST, RESP_OKAY);
		rdr(ADDR_FC_CFG, '1, {26'h0, FC_CFG_RST}, RESP_OKAY);
		rdr(ADDR_FC_STAT, '1, 32'h0, RESP_OKAY);
		rdr(12'hFFC, '1, 32'h0, RESP_SLVERR);
		wr(12'h7F0, 32'h0000_0023, RESP_SLVERR);
		wr(ADDR_FC_STAT, 32'hFFFF_FFFF, RESP_OKAY);
		lfsr_q = nxt(lfsr_q);
		t = lfsr_q[15:0];
		wfc({t, 16'h0007});
		rdr(ADDR_PAUSE_CTRL, '1, {t, 16'h0006}, RESP_OKAY);
		wr(ADDR_FC_CFG, 32'h0000_0037, RESP_OKAY);
		rdr(ADDR_FC_CFG, '1, 32'h0000_0037, RESP_OKAY);
		$display("registers done");
		// Filter flag over pass, promiscuous and frame kinds
		for (int k = 0; k < 12; k++)
		begin
			if (k % 3 == 0)
			begin
				repeat (3) @(posedge sys_clk);
				wfc({29'h0, k[3], 2'b10});
				wr(ADDR_FC_CFG, {26'h0, 3'h4, k == 6, 2'h3}, RESP_OKAY);
			end
			lfsr_q = nxt(lfsr_q);
			am = lfsr_q[0];
			c = {k / 3 == 2 || ((k % 3 == 0) ? k[3] : am), k % 3 == 0, k % 3 == 1};
			rxf(k % 3 != 2, k % 3 == 1, am, 16'h0, c, 3'h7);
		end
		$display("filter done");
		// Hold-off length, reload, zero time and slow speed
		repeat (3) @(posedge sys_clk);
		wfc(32'h2);
		wr(ADDR_FC_CFG, 32'h23, RESP_OKAY);
		rxf(1, 0, 0, 16'h3, 3'h2, 3'h7);
		hm(384, 387);
		rxf(1, 0, 0, 16'h4, 3'h2, 3'h7);
		repeat (100) @(posedge sys_clk);
		rxf(1, 0, 0, 16'h1, 3'h2, 3'h7);
		hm(128, 133);
		rxf(1, 0, 0, 16'h5, 3'h2, 3'h7);
		repeat (50) @(posedge sys_clk);
		rxf(1, 0, 0, 16'h0, 3'h2, 3'h7);
		hm(0, 4);
		wr(ADDR_FC_CFG, 32'h3, RESP_OKAY);
		rxf(1, 0, 0, 16'h1, 3'h2, 3'h7);
		hm(1280, 1283);
		wr(ADDR_FC_CFG, 32'h22, RESP_OKAY);
		rxf(1, 0, 0, 16'h2, 3'h0, 3'h5);
		hm(0, 0);
		wfc(32'h0);
		wr(ADDR_FC_CFG, 32'h23, RESP_OKAY);
		rxf(1, 0, 0, 16'h2, 3'h0, 3'h7);
		hm(0, 0);
		$display("hold-off done");
		// Pause frame sending, slow and prompt far side
		for (int k = 0; k < 2; k++)
		begin
			wfc({t, 16'h0});
			tx_dly <= k ? 8'h00 : 8'h14;
			wr(ADDR_FC_CFG, 32'h2B, RESP_OKAY);
			repeat (2) @(posedge sys_clk);
			chk("req", {34'h1FFFF, 17'h0, 1'b1, t}, {17'h0, pause_frame_req, pause_frame_time});
			if (k == 0) rdr(ADDR_PAUSE_CTRL, '1, {t, 16'h1}, RESP_OKAY);
			wfc({t, 16'h0});
			chk("req end", {34'h1, 34'h0}, {33'h0, pause_frame_req});
		end
		for (int k = 0; k < 2; k++)
		begin
			wr(ADDR_FC_CFG, k ? 32'h2A : 32'h29, RESP_OKAY);
			repeat (4) @(posedge sys_clk);
			chk("no req", {34'h1, 34'h0}, {33'h0, pause_frame_req});
		end
		$display("pause send done");
		// Backpressure over decode, duplex and transmit enable
		for (int k = 0; k < 4; k++)
		begin
			wr(ADDR_FC_CFG, 32'h22, RESP_OKAY);
			wfc({30'h0, k != 3, 1'b0});
			wr(ADDR_FC_CFG, k == 1 ? 32'h30 : k == 2 ? 32'h33 : 32'h32, RESP_OKAY);
			repeat (3) @(posedge sys_clk);
			chk("bp", {34'h1, 33'h0, k == 0}, {33'h0, backpressure});
			rdr(ADDR_PAUSE_CTRL, 32'h1, k == 0, RESP_OKAY);
		end
		wr(ADDR_FC_CFG, 32'h22, RESP_OKAY);
		$display("backpressure done");
		repeat (5) @(posedge sys_clk);
		summarize();
	end
endmodule : tb_top
